/* adcm_defs.svh */
`ifndef ADCM_DEFS_SVH
`define ADCM_DEFS_SVH
`define ADCM_MODE_ADDR 16'hff28
`define ADCM_MODE_RST 8'h00
`define ADCM_RUN_BIT 7
`define ADCM_ZERO_BIT 6
`define ADCM_TS_HI 5
`define ADCM_TS_LO 3
`define ADCM_LV_HI 2
`define ADCM_LV_LO 1
`define ADCM_CMP_BIT 0
`define ADCM_LV_NORMAL 2'h0
`define ADCM_LV_HS1 2'h2
`define ADCM_LV_HS2 2'h3
`define ADCM_TS_HS1_A 3'h4
`define ADCM_TS_HS1_B 3'h6
`define ADCM_TS_HS2_A 3'h5
`define ADCM_TS_HS2_B 3'h7
`define ADCM_RES_W 10
`define ADCM_RES_PAD 6'h00
`define ADCM_SAR_TOP 10'h200
`define ADCM_SAR_LSB 10'h001
`define ADCM_SAMPLE_LAST 5'h0b
`define ADCM_TOTAL_LAST 5'h15
`define ADCM_HALF_STEP 5'h02
`define ADCM_DIV0 5'h18
`define ADCM_DIV1 5'h10
`define ADCM_DIV2 5'h0c
`define ADCM_DIV3 5'h08
`define ADCM_DIV4 5'h06
`define ADCM_DIV5 5'h04
`define ADCM_DIV6 5'h03
`define ADCM_DIV7 5'h02
`endif

/* adcm_pkg.sv */
`include "adcm_defs.svh"
package adcm_pkg;
    typedef logic [`ADCM_RES_W-1:0] adcm_res_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_DECIDE = 3'b100
    } adcm_state_e;
    typedef struct packed {
        logic [7:0] mode;
        adcm_state_e state;
        logic [4:0] acc;
        logic [4:0] cnt;
        logic wait_done;
        adcm_res_t result;
        logic load;
        logic irq;
    } adcm_ctrl_s;
    typedef struct packed {
        adcm_res_t value;
        adcm_res_t ptr;
        logic done;
    } adcm_sar_s;
endpackage

/* adcm_sar.sv */
`timescale 1ns/100ps
`include "adcm_defs.svh"
module adcm_sar (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic cmp_in,
    output adcm_pkg::adcm_res_t trial_out,
    output logic done_out
);
    import adcm_pkg::*;
    adcm_sar_s q_ff;
    adcm_sar_s nxt_q;
    adcm_res_t kept;

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.done = 1'b0;
        // Comparator high keeps the trial bit
        kept = cmp_in ? q_ff.value : (q_ff.value & ~q_ff.ptr);
        if (clear_in)
        begin
            nxt_q.value = `ADCM_SAR_TOP;
            nxt_q.ptr = `ADCM_SAR_TOP;
        end
        else if (step_in && (q_ff.ptr != '0))
        begin
            nxt_q.ptr = q_ff.ptr >> 1;
            nxt_q.value = kept | (q_ff.ptr >> 1);
            nxt_q.done = (q_ff.ptr == `ADCM_SAR_LSB);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
            q_ff <= '0;
        else
            q_ff <= nxt_q;
    end

    assign trial_out = q_ff.value;
    assign done_out = q_ff.done;

    sar_done_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        done_out |-> (q_ff.ptr == '0))
        else $error("Result marked done before the last bit");
endmodule

/* adcm_ctrl.sv */
`timescale 1ns/100ps
`include "adcm_defs.svh"
module adcm_ctrl (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic mem_wr_in,
    input wire logic mem_bit_wr_in,
    input wire logic [2:0] mem_bit_sel_in,
    input wire logic [7:0] mem_wdata_in,
    output logic mem_wait_out,
    output logic [7:0] mode_rdata_out,
    input wire logic cmp_result_in,
    output logic comparator_power_out,
    output logic conversion_active_out,
    output logic sample_hold_out,
    output logic conv_clk_out,
    output adcm_pkg::adcm_res_t trial_out,
    output logic [15:0] conversion_result_word_out,
    output logic result_load_out,
    output logic conversion_end_irq_out
);
    import adcm_pkg::*;
    adcm_ctrl_s q_ff;
    adcm_ctrl_s nxt_q;
    logic wr_req;
    logic take;
    logic [7:0] wr_val;
    logic [2:0] ts;
    logic [1:0] lv;
    logic legal;
    logic go;
    logic [4:0] div_half;
    logic [4:0] sum;
    logic tick;
    logic sar_clear;
    logic sar_step;
    logic sar_done;

    assign wr_req = (mem_addr_in == `ADCM_MODE_ADDR) && (mem_wr_in || mem_bit_wr_in);
    // First cycle of a write to the mode address always stalls the bus
    assign take = wr_req && q_ff.wait_done;
    assign mem_wait_out = wr_req && !q_ff.wait_done;

    always_comb
    begin
        wr_val = q_ff.mode;
        if (mem_wr_in)
            wr_val = mem_wdata_in;
        else
            wr_val[mem_bit_sel_in] = mem_wdata_in[0];
        wr_val[`ADCM_ZERO_BIT] = 1'b0;
    end

    // Fields used live; changing them mid-run is software's fault
    assign ts = q_ff.mode[`ADCM_TS_HI:`ADCM_TS_LO];
    assign lv = q_ff.mode[`ADCM_LV_HI:`ADCM_LV_LO];

    // Prohibited combinations hold the converter idle
    assign legal = (lv == `ADCM_LV_NORMAL)
        || ((lv == `ADCM_LV_HS1) && ((ts == `ADCM_TS_HS1_A) || (ts == `ADCM_TS_HS1_B)))
        || ((lv == `ADCM_LV_HS2) && ((ts == `ADCM_TS_HS2_A) || (ts == `ADCM_TS_HS2_B)));

    assign go = q_ff.mode[`ADCM_RUN_BIT] && q_ff.mode[`ADCM_CMP_BIT] && legal;

    // Divider kept in half clocks so that 1.5 needs no second clock
    always_comb
    begin
        unique case (ts)
            3'h0: div_half = `ADCM_DIV0;
            3'h1: div_half = `ADCM_DIV1;
            3'h2: div_half = `ADCM_DIV2;
            3'h3: div_half = `ADCM_DIV3;
            3'h4: div_half = `ADCM_DIV4;
            3'h5: div_half = `ADCM_DIV5;
            3'h6: div_half = `ADCM_DIV6;
            3'h7: div_half = `ADCM_DIV7;
        endcase
    end

    assign sum = q_ff.acc + `ADCM_HALF_STEP;
    assign tick = (q_ff.state != ST_IDLE) && go && (sum >= div_half);
    assign sar_clear = tick && (q_ff.state == ST_SAMPLE) && (q_ff.cnt == `ADCM_SAMPLE_LAST);
    assign sar_step = tick && (q_ff.state == ST_DECIDE);

    adcm_sar u_sar (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .clear_in(sar_clear),
        .step_in(sar_step),
        .cmp_in(cmp_result_in),
        .trial_out(trial_out),
        .done_out(sar_done)
    );

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.load = 1'b0;
        nxt_q.irq = 1'b0;
        nxt_q.wait_done = wr_req && !q_ff.wait_done;
        if (take)
            nxt_q.mode = wr_val;
        // Done arrives one cycle after the LSB step; a drop of go kills it
        if (sar_done && go)
        begin
            nxt_q.result = trial_out;
            nxt_q.load = 1'b1;
            nxt_q.irq = 1'b1;
        end
        unique case (q_ff.state)
            ST_IDLE:
            begin
                nxt_q.acc = '0;
                nxt_q.cnt = '0;
                if (go)
                    nxt_q.state = ST_SAMPLE;
            end
            ST_SAMPLE, ST_DECIDE:
            begin
                if (!go)
                begin
                    nxt_q.state = ST_IDLE;
                    nxt_q.acc = '0;
                    nxt_q.cnt = '0;
                end
                else if (tick)
                begin
                    nxt_q.acc = sum - div_half;
                    nxt_q.cnt = q_ff.cnt + 5'h01;
                    if (sar_clear)
                        nxt_q.state = ST_DECIDE;
                    if ((q_ff.state == ST_DECIDE) && (q_ff.cnt == `ADCM_TOTAL_LAST))
                    begin
                        // Repeat: next conversion starts sampling at once
                        nxt_q.state = ST_SAMPLE;
                        nxt_q.cnt = '0;
                    end
                end
                else
                    nxt_q.acc = sum;
            end
            default:
            begin
                nxt_q.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            q_ff <= '0;
            q_ff.mode <= `ADCM_MODE_RST;
            q_ff.state <= ST_IDLE;
        end
        else
            q_ff <= nxt_q;
    end

    assign mode_rdata_out = q_ff.mode;
    assign comparator_power_out = q_ff.mode[`ADCM_CMP_BIT];
    assign conversion_active_out = (q_ff.state != ST_IDLE);
    assign sample_hold_out = (q_ff.state == ST_SAMPLE);
    assign conv_clk_out = tick;
    assign conversion_result_word_out = {`ADCM_RES_PAD, q_ff.result};
    assign result_load_out = q_ff.load;
    assign conversion_end_irq_out = q_ff.irq;

    wr_wait_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (wr_req && !q_ff.wait_done) |-> mem_wait_out ##1 (!wr_req || !mem_wait_out))
        else $error("Mode write wait cycle wrong");

    reset_clear_a: assert property (@(posedge core_clk_in)
        !resetn_in |=> (mode_rdata_out == `ADCM_MODE_RST))
        else $error("Mode register not cleared by reset");

    zero_bit_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !mode_rdata_out[`ADCM_ZERO_BIT])
        else $error("Bit six reads as one");

    cmp_power_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (take && mem_wr_in) |=> (comparator_power_out == $past(mem_wdata_in[`ADCM_CMP_BIT])))
        else $error("Comparator power does not follow write");

    run_stop_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (!q_ff.mode[`ADCM_RUN_BIT] || !q_ff.mode[`ADCM_CMP_BIT]) |=> !conversion_active_out)
        else $error("Converter active while stopped");

    illegal_idle_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !legal |=> (!conversion_active_out && !conv_clk_out))
        else $error("Prohibited mode converts");

    abort_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !go |=> (!conversion_end_irq_out && !result_load_out))
        else $error("Aborted conversion raised an end event");

    irq_load_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        conversion_end_irq_out |-> (result_load_out
            && (conversion_result_word_out[`ADCM_RES_W-1:0] == $past(trial_out))))
        else $error("End interrupt without result load");

    irq_gap_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        conversion_end_irq_out |=> !conversion_end_irq_out [*8])
        else $error("Conversions closer than allowed");
endmodule

/* adcm_afe_model.sv */
`timescale 1ns/100ps
module adcm_afe_model (
    input wire logic core_clk_in,
    input wire logic power_in,
    input wire logic sample_in,
    input wire logic [9:0] trial_in,
    input wire logic [9:0] level_in,
    output logic cmp_out
);
    logic [9:0] held = 10'h000;
    logic junk = 1'b0;
    // Comparator needs 1 us, 100 clocks, after power-up to settle
    localparam int SETTLE = 100;
    int settle = 0;
    always @(posedge core_clk_in)
    begin
        junk <= ~junk;
        if (!power_in)
            settle <= 0;
        else if (settle < SETTLE)
            settle <= settle + 1;
        if (sample_in)
        begin
            held <= level_in;
        end
    end
    // Unpowered or unsettled comparator has no valid answer, so it toggles
    assign cmp_out = (power_in && settle >= SETTLE) ? (held >= trial_in) : junk;
endmodule

/* test_adc_mode_control.sv */
`timescale 1ns/100ps
`include "adcm_defs.svh"
module test_adc_mode_control;
    import adcm_pkg::*;
    logic core_clk_in = 0;
    logic resetn_in = 0;
    logic [15:0] addr = 16'h0000;
    logic wr = 0;
    logic bwr = 0;
    logic [2:0] bsel = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [9:0] level = 10'h000;
    logic wait_o, cmp, pwr, active, sh, load, irq, tck;
    logic [7:0] rdata;
    adcm_res_t trial;
    logic [15:0] result;
    logic [15:0] keep;
    int err_total = 0;
    int n_tests = 0;
    int cyc;
    int ticks;
    logic [4:0] cfg[12] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c,
        5'h12, 5'h1a, 5'h17, 5'h1f};
    int per[12] = '{264, 176, 132, 88, 66, 44, 33, 22, 66, 33, 44, 22};
    adcm_ctrl uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .mem_addr_in(addr),
        .mem_wr_in(wr), .mem_bit_wr_in(bwr), .mem_bit_sel_in(bsel), .mem_wdata_in(wdata),
        .mem_wait_out(wait_o), .mode_rdata_out(rdata), .cmp_result_in(cmp),
        .comparator_power_out(pwr), .conversion_active_out(active), .sample_hold_out(sh),
        .conv_clk_out(tck), .trial_out(trial), .conversion_result_word_out(result),
        .result_load_out(load), .conversion_end_irq_out(irq));
    adcm_afe_model afe (.core_clk_in(core_clk_in), .power_in(pwr), .sample_in(sh),
        .trial_in(trial), .level_in(level), .cmp_out(cmp));
    always #5 core_clk_in = ~core_clk_in;
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0, exp}, {15'h0, got});
    endtask
    // Strobe held until the edge where wait is seen low
    task automatic bus_write(input logic [15:0] a, input logic b, input logic [2:0] s,
        input logic [7:0] d);
        logic w;
        int n;
        @(posedge core_clk_in);
        #1;
        addr = a;
        wr = !b;
        bwr = b;
        bsel = s;
        wdata = d;
        #1;
        w = wait_o;
        chk_bit("write wait", a == `ADCM_MODE_ADDR, w);
        n = 0;
        while (w && n < 4)
        begin
            @(posedge core_clk_in);
            #1;
            w = wait_o;
            n++;
        end
        if (w)
        begin
            chk_bit("write wait end", 1'b0, w);
            stop_test();
        end
        @(posedge core_clk_in);
        #1;
        wr = 0;
        bwr = 0;
    endtask
    task automatic wait_load(output int c, output int t);
        c = 0;
        t = 0;
        do
        begin
            @(posedge core_clk_in);
            #1;
            c++;
            if (tck === 1'b1)
                t++;
        end while (load !== 1'b1 && c < 1000);
        if (c >= 1000)
        begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic quiet(input int n, input string what);
        logic bad;
        bad = 0;
        repeat (n)
        begin
            @(posedge core_clk_in);
            #1;
            if (load !== 1'b0 || active !== 1'b0 || irq !== 1'b0)
                bad = 1;
        end
        chk_bit(what, 1'b0, bad);
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk_in);
        #1;
        resetn_in = 1;
        chk_word("mode after reset", 16'h0000, {8'h00, rdata});
        chk_word("result after reset", 16'h0000, result);
        $display("test reset done");
        bus_write(`ADCM_MODE_ADDR, 0, 3'h0, 8'h7e);
        chk_word("mode byte", 16'h003e, {8'h00, rdata});
        bus_write(`ADCM_MODE_ADDR, 1, 3'h6, 8'h01);
        chk_word("mode bit6", 16'h003e, {8'h00, rdata});
        bus_write(16'hff29, 0, 3'h0, 8'hff);
        chk_word("mode unmapped", 16'h003e, {8'h00, rdata});
        $display("test register done");
        for (int i = 0; i < 12; i++)
        begin
            level = 10'h2a5 ^ 10'(i * 37);
            bus_write(`ADCM_MODE_ADDR, 1, 3'h7, 8'h00);
            bus_write(`ADCM_MODE_ADDR, 0, 3'h0, {2'b00, cfg[i], 1'b1});
            chk_word("mode fields", {10'h0, cfg[i], 1'b1}, {8'h00, rdata});
            chk_bit("comparator power", 1'b1, pwr);
            repeat (100) @(posedge core_clk_in);
            bus_write(`ADCM_MODE_ADDR, 1, 3'h7, 8'h01);
            wait_load(cyc, ticks);
            chk_word("result", {6'h00, level}, result);
            chk_bit("end irq", 1'b1, irq);
            wait_load(cyc, ticks);
            chk_word("period", 16'(per[i]), 16'(cyc));
            chk_word("ticks", 16'h0016, 16'(ticks));
        end
        $display("test conversion times done");
        keep = result;
        // New level would show in the result if the abort failed
        level = ~level;
        bus_write(`ADCM_MODE_ADDR, 1, 3'h7, 8'h00);
        quiet(300, "abort quiet");
        chk_word("result kept", keep, result);
        $display("test abort done");
        bus_write(`ADCM_MODE_ADDR, 0, 3'h0, 8'h80);
        chk_bit("comparator off", 1'b0, pwr);
        quiet(100, "run without comparator");
        bus_write(`ADCM_MODE_ADDR, 0, 3'h0, 8'h03);
        bus_write(`ADCM_MODE_ADDR, 1, 3'h7, 8'h01);
        quiet(100, "prohibited speed");
        $display("test refusal done");
        stop_test();
    end
endmodule
